//--- hdl/clip_pkg.sv
`default_nettype none
package clip_pkg;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] DROP_OFF = 8'h08;
	localparam int BYP_BIT = 16;
	localparam int PRD_BIT = 17;
	localparam int GEO_BIT = 18;
	localparam int LIN_BIT = 19;
	localparam int INT_BIT = 20;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int NVIEW = 6;
	localparam int NPOS = 4;
	localparam int NA = 4;
	localparam int USR_DEF = 8;
	localparam int W_DEF = 16;
	localparam int TF_DEF = 12;
	localparam logic [1:0] KIND_POINT = 2'h0;
	localparam logic [1:0] KIND_LINE = 2'h1;
	localparam logic [1:0] KIND_TRI = 2'h2;
	typedef enum logic [2:0] {S_IDLE, S_PLANE, S_EDGE, S_DIV, S_MIX, S_EMIT} st_t;
endpackage : clip_pkg
`default_nettype wire

//--- hdl/prim_clipper.sv
// Functional notes
// [RULE1] A vertex is in the view volume when -w <= x, y, z <= w.
// [RULE2] The number of user half-spaces is a parameter, at least 8.
// [RULE3] Clip volume is the view volume cut by every enabled user half-space.
// [RULE4] A point is inside user half-space k only when its distance k exceeds 0.
// [RULE5] Points use their own distance; new vertices get interpolated distances.
// [RULE6] Software enables each user half-space separately; only enabled ones apply.
// [RULE7] Near/far bypass skips the z against w planes.
// [RULE8] A point inside passes unchanged, otherwise it is dropped.
// [RULE9] A line fully inside passes untouched, fully outside is dropped.
// [RULE10] An outside line end becomes t*P1+(1-t)*P2 with t in [0,1].
// [RULE11] Polygons pass whole or are clipped with new boundary edges, or dropped.
// [RULE12] A polygon crossing a boundary edge keeps a vertex on that edge.
// [RULE13] Negated distances must cover the cut region exactly once.
// [RULE14] At least 8 half-space enables, all cleared by reset.
// [RULE15] Attributes of inside vertices pass unmodified.
// [RULE16] New vertex attributes are t*c1+(1-t)*c2 on all four components.
// [RULE17] Clip one half-space at a time, attributes in the same pass.
// [RULE18] Screen-linear attributes use a t adjusted to be linear on screen.
// [RULE19] Integer attributes are never interpolated.
// [RULE20] Only stream zero passes; without a geometry stage all is stream zero.
// [RULE21] Pre-raster drop discards all primitives and ignores buffer wipes.
// [RULE22] Integer window shifts of unclipped primitives give shifted fragments.
// [RULE23] Valid/ready in and out; input stalls while a primitive is worked.
// [RULE24] All tests and blends are fixed point in clip space, before divide.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module prim_clipper
	import clip_pkg::*;
#(
	parameter int W = W_DEF,
	parameter int NUP = USR_DEF, // [RULE2]
	parameter int TF = TF_DEF,
	localparam int NC = NPOS + NUP + NA,
	localparam int VW = NC * W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [1:0] in_kind,
	input wire logic [1:0] in_stream,
	input wire logic [VW-1:0] in_v0,
	input wire logic [VW-1:0] in_v1,
	input wire logic [VW-1:0] in_v2,
	output logic out_valid,
	input wire logic out_ready,
	output logic [VW-1:0] out_vtx,
	output logic out_first,
	output logic out_last,
	output logic [1:0] out_kind,
	input wire logic buffer_wipe_cmd,
	output logic wipe_out
);
	localparam int NPL = NVIEW + NUP;
	localparam int MAXV = 3 + NPL;
	localparam int CW = $clog2(MAXV + 1);
	localparam int PW = $clog2(NPL + 1);
	localparam int AB = (NPOS + NUP) * W;
	localparam logic [TF:0] ONE = {1'b1, {TF{1'b0}}};

	st_t st_r;
	logic [NUP-1:0] user_plane_enable_i;
	logic byp_r, pre_raster_drop, geo_r, lin_r, int_r;
	logic [15:0] drop_cnt_r;
	logic [31:0] rdata_r, ctrl_rd;
	logic in_ready_r, out_valid_r, out_first_r, out_last_r, wipe_r, sel_r, ph_r;
	logic [VW-1:0] out_vtx_r;
	logic [1:0] kind_r;
	logic [CW-1:0] cnt_r, ei_r, oc_r, j_r, ne, ib, widx;
	logic [PW-1:0] pl_r;
	logic [TF:0] t_r, s_r, dv_q, q_new, qf;
	logic [W+2:0] dv_rem, dv_den, rem_new;
	logic [$clog2(TF+1)-1:0] dv_k;
	logic [VW-1:0] vbuf [2][MAXV];
	logic [VW-1:0] va, vb, wdata, mixv;
	logic acc, kill, ina, inb, pe, we, ok, dv_ge;
	logic signed [W:0] d_a, d_b;
	logic signed [W+1:0] da, db, num2, den2;
	logic signed [W+TF+1:0] p2;
	logic signed [W-1:0] wa, wb;

	function automatic logic signed [W:0] pdist(input logic [VW-1:0] v, input logic [PW-1:0] p);
		logic signed [W:0] x, y, z, w;
		x = {v[W-1], v[0+:W]};
		y = {v[2*W-1], v[W+:W]};
		z = {v[3*W-1], v[2*W+:W]};
		w = {v[4*W-1], v[3*W+:W]};
		case (p)
			0: pdist = w - x;
			1: pdist = w + x;
			2: pdist = w - y;
			3: pdist = w + y;
			4: pdist = w - z;
			5: pdist = w + z;
			default: pdist = {v[(p-2)*W+W-1], v[(p-2)*W+:W]};
		endcase
	endfunction : pdist

	// The view test is inclusive but the user test is strict, so a vertex at
	// distance zero belongs to neither a plane nor its negation.
	function automatic logic in_vol(input logic [VW-1:0] v, input logic [PW-1:0] p);
		logic signed [W:0] d;
		d = pdist(v, p);
		in_vol = (p < NVIEW) ? (d >= 0) : (d > 0); // [RULE1] [RULE4] [RULE13]
	endfunction : in_vol

	function automatic logic signed [W-1:0] mix(input logic signed [W-1:0] a, input logic signed [W-1:0] b,
			input logic [TF:0] t);
		logic signed [W+TF+2:0] s;
		s = a * $signed({1'b0, t}) + b * $signed({1'b0, ONE - t});
		mix = s[TF+:W];
	endfunction : mix

	function automatic logic [W+2:0] mag(input logic signed [W+1:0] v);
		mag = {1'b0, (v < 0) ? -v : v};
	endfunction : mag

	assign acc = in_valid && in_ready_r;
	assign kill = pre_raster_drop || (geo_r && in_stream != 2'h0); // [RULE20] [RULE21]
	assign ib = (ei_r + 1'b1 == cnt_r) ? '0 : CW'(ei_r + 1'b1);
	assign va = vbuf[sel_r][ei_r];
	assign vb = vbuf[sel_r][ib];
	assign ina = in_vol(va, pl_r);
	assign inb = in_vol(vb, pl_r);
	assign ne = (kind_r == KIND_TRI) ? cnt_r : CW'(cnt_r != '0);
	assign d_a = pdist(va, pl_r);
	assign d_b = pdist(vb, pl_r);
	assign da = {d_a[W], d_a};
	assign db = {d_b[W], d_b};
	assign wa = va[3*W+:W];
	assign wb = vb[3*W+:W];
	assign p2 = wa * $signed({1'b0, t_r});
	assign num2 = p2[TF+:W+2];
	assign den2 = {{2{mixv[4*W-1]}}, mixv[3*W+:W]};
	assign ok = cnt_r != '0 && (kind_r != KIND_TRI || cnt_r >= 3);
	assign dv_ge = dv_rem >= dv_den;
	assign q_new = {dv_q[TF-1:0], dv_ge};
	assign rem_new = (dv_ge ? dv_rem - dv_den : dv_rem) << 1;
	// A zero divisor only arises for degenerate w; clamping keeps t in range.
	assign qf = (q_new > ONE) ? ONE : q_new; // [RULE10]
	assign pe = (pl_r < NVIEW) ? !(byp_r && pl_r >= 4) : user_plane_enable_i[pl_r-NVIEW]; // [RULE3] [RULE6] [RULE7]

	always_comb begin
		for (int c = 0; c < NC; c++) begin
			if (c >= NPOS + NUP && int_r)
				mixv[c*W+:W] = va[c*W+:W]; // [RULE19]
			else if (c >= NPOS + NUP && lin_r)
				mixv[c*W+:W] = mix(va[c*W+:W], vb[c*W+:W], s_r); // [RULE18]
			else
				mixv[c*W+:W] = mix(va[c*W+:W], vb[c*W+:W], t_r); // [RULE5] [RULE10] [RULE16] [RULE24]
		end
	end

	always_comb begin
		we = 1'b0;
		wdata = va;
		widx = oc_r;
		if (st_r == S_EDGE) begin
			if (ei_r == ne)
				we = kind_r == KIND_LINE && cnt_r != '0 && ina; // [RULE9]
			else
				we = ina; // [RULE15]
		end else if (st_r == S_MIX) begin
			we = !(lin_r && !ph_r);
			wdata = mixv;
		end
	end

	// Two ping-pong vertex lists: each enabled plane reads one and writes the other.
	always_ff @(posedge clk) begin
		if (acc) begin
			vbuf[0][0] <= in_v0;
			vbuf[0][1] <= in_v1;
			vbuf[0][2] <= in_v2;
		end else if (we) begin
			vbuf[!sel_r][widx] <= wdata; // [RULE17]
		end
	end

	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[NUP-1:0] = user_plane_enable_i;
		ctrl_rd[BYP_BIT] = byp_r;
		ctrl_rd[PRD_BIT] = pre_raster_drop;
		ctrl_rd[GEO_BIT] = geo_r;
		ctrl_rd[LIN_BIT] = lin_r;
		ctrl_rd[INT_BIT] = int_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{user_plane_enable_i, byp_r, pre_raster_drop, geo_r, lin_r, int_r} <= '0; // [RULE14]
		end else if (reg_wr && reg_addr == CTRL_OFF) begin
			user_plane_enable_i <= reg_wdata[NUP-1:0]; // [RULE6]
			byp_r <= reg_wdata[BYP_BIT];
			pre_raster_drop <= reg_wdata[PRD_BIT];
			geo_r <= reg_wdata[GEO_BIT];
			lin_r <= reg_wdata[LIN_BIT];
			int_r <= reg_wdata[INT_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= CTRL_RST;
		else if (reg_rd && reg_addr == CTRL_OFF)
			rdata_r <= ctrl_rd;
		else if (reg_rd && reg_addr == STAT_OFF)
			rdata_r <= {30'h0000_0000, out_valid_r, st_r != S_IDLE};
		else if (reg_rd && reg_addr == DROP_OFF)
			rdata_r <= {16'h0000, drop_cnt_r};
		else
			rdata_r <= 32'h0000_0000;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wipe_r <= 1'b0;
		else
			wipe_r <= buffer_wipe_cmd && !pre_raster_drop; // [RULE21]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= S_IDLE;
			in_ready_r <= 1'b0;
			{out_valid_r, out_first_r, out_last_r, sel_r, ph_r} <= '0;
			{out_vtx_r, kind_r, cnt_r, ei_r, oc_r, j_r, pl_r} <= '0;
			{t_r, s_r, dv_q, dv_rem, dv_den, dv_k, drop_cnt_r} <= '0;
		end else begin
			unique case (st_r)
				S_IDLE: begin
					in_ready_r <= !acc;
					if (acc) begin
						kind_r <= in_kind;
						if (kill) begin
							drop_cnt_r <= drop_cnt_r + 1'b1; // [RULE20] [RULE21]
							in_ready_r <= 1'b1;
						end else begin
							sel_r <= 1'b0;
							cnt_r <= CW'(in_kind) + 1'b1;
							pl_r <= '0;
							st_r <= S_PLANE;
						end
					end
				end
				S_PLANE: begin
					if (pl_r == PW'(NPL)) begin
						j_r <= '0;
						st_r <= S_EMIT;
					end else if (!pe) begin
						pl_r <= pl_r + 1'b1; // [RULE3]
					end else begin
						ei_r <= '0;
						oc_r <= '0;
						st_r <= S_EDGE;
					end
				end
				S_EDGE: begin
					if (ei_r == ne) begin
						cnt_r <= oc_r + CW'(we);
						sel_r <= !sel_r;
						pl_r <= pl_r + 1'b1; // [RULE17]
						st_r <= S_PLANE;
					end else begin
						oc_r <= oc_r + CW'(we);
						if (ina != inb) begin
							dv_rem <= mag(db); // [RULE11] [RULE12]
							dv_den <= mag(db - da);
							dv_k <= '0;
							ph_r <= 1'b0;
							st_r <= S_DIV;
						end else begin
							ei_r <= ei_r + 1'b1;
						end
					end
				end
				S_DIV: begin
					dv_rem <= rem_new;
					dv_q <= q_new;
					dv_k <= dv_k + 1'b1;
					if (dv_k == TF) begin
						if (ph_r)
							s_r <= qf; // [RULE18]
						else
							t_r <= qf; // [RULE10]
						st_r <= S_MIX;
					end
				end
				S_MIX: begin
					if (lin_r && !ph_r) begin
						dv_rem <= mag(num2); // [RULE18]
						dv_den <= mag(den2);
						dv_k <= '0;
						ph_r <= 1'b1;
						st_r <= S_DIV;
					end else begin
						oc_r <= oc_r + 1'b1;
						ei_r <= ei_r + 1'b1;
						st_r <= S_EDGE;
					end
				end
				S_EMIT: begin
					if (!out_valid_r || out_ready) begin
						if (ok && j_r < cnt_r) begin
							out_vtx_r <= vbuf[sel_r][j_r]; // [RULE8] [RULE22]
							out_first_r <= j_r == '0;
							out_last_r <= j_r == cnt_r - 1'b1;
							out_valid_r <= 1'b1; // [RULE23]
							j_r <= j_r + 1'b1;
						end else begin
							out_valid_r <= 1'b0;
							in_ready_r <= 1'b1;
							st_r <= S_IDLE;
							if (!ok)
								drop_cnt_r <= drop_cnt_r + 1'b1; // [RULE8] [RULE9] [RULE11]
						end
					end
				end
			endcase
		end
	end

	assign reg_rdata = rdata_r;
	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_vtx = out_vtx_r;
	assign out_first = out_first_r;
	assign out_last = out_last_r;
	assign out_kind = kind_r;
	assign wipe_out = wipe_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ready_stall_a: assert property (st_r != S_IDLE |-> !in_ready_r) else $error("input not stalled"); // [RULE23]
	stream_drop_a: assert property (acc && geo_r && in_stream != 2'h0 |=> st_r == S_IDLE // [RULE20]
		&& drop_cnt_r == $past(drop_cnt_r) + 1'b1) else $error("side stream not dropped");
	raster_drop_a: assert property (acc && pre_raster_drop |=> st_r == S_IDLE && !out_valid_r) // [RULE21]
		else $error("primitive passed during drop");
	wipe_block_a: assert property (buffer_wipe_cmd && pre_raster_drop |=> !wipe_out) else $error("wipe not ignored"); // [RULE21]
	plane_skip_a: assert property (st_r == S_PLANE && pl_r >= NVIEW && pl_r < NPL // [RULE6]
		&& !user_plane_enable_i[pl_r-NVIEW] |=> st_r == S_PLANE && pl_r == $past(pl_r) + 1'b1)
		else $error("disabled plane applied");
	bypass_skip_a: assert property (st_r == S_PLANE && byp_r && (pl_r == 4 || pl_r == 5) // [RULE7]
		|=> st_r == S_PLANE) else $error("z plane not bypassed");
	t_range_a: assert property (st_r == S_MIX |-> t_r <= ONE && s_r <= ONE) else $error("weight out of range"); // [RULE10]
	tri_size_a: assert property (out_valid_r && kind_r == KIND_TRI |-> cnt_r >= 3) else $error("degenerate polygon out"); // [RULE11]
	int_attr_a: assert property (st_r == S_MIX && int_r |-> mixv[VW-1-:NA*W] == va[VW-1-:NA*W]) // [RULE19]
		else $error("integer attribute blended");
	point_one_a: assert property (out_valid_r && kind_r == KIND_POINT |-> out_first_r && out_last_r) // [RULE8]
		else $error("point grew vertices");
endmodule : prim_clipper
`default_nettype wire

//--- verif/raster_sink.sv
`timescale 1ns/1ns
`default_nettype none
module raster_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic out_ready
);
	// A slow rasterizer takes every other cycle, so each vertex must be held.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= slow ? ~out_ready : 1'b1;
		end
	end
endmodule : raster_sink
`default_nettype wire

//--- verif/prim_clipper_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module prim_clipper_tb_top;
	import clip_pkg::*;
	localparam int VW = (NPOS + USR_DEF + NA) * W_DEF;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic in_valid = 1'b0;
	logic in_ready;
	logic [1:0] in_kind = 2'h0;
	logic [1:0] in_stream = 2'h0;
	logic [VW-1:0] in_v0 = '0;
	logic [VW-1:0] in_v1 = '0;
	logic [VW-1:0] in_v2 = '0;
	logic out_valid;
	logic out_ready;
	logic [VW-1:0] out_vtx;
	logic out_first;
	logic out_last;
	logic [1:0] out_kind;
	logic buffer_wipe_cmd = 1'b0;
	logic wipe_out;
	logic slow = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int nv;
	logic [VW-1:0] got [0:3];
	logic fst;
	logic lst;
	logic [1:0] gk;
	always #50 clk = ~clk;
	prim_clipper u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_kind(in_kind),
		.in_stream(in_stream), .in_v0(in_v0), .in_v1(in_v1), .in_v2(in_v2), .out_valid(out_valid),
		.out_ready(out_ready), .out_vtx(out_vtx), .out_first(out_first), .out_last(out_last),
		.out_kind(out_kind), .buffer_wipe_cmd(buffer_wipe_cmd), .wipe_out(wipe_out));
	raster_sink u_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .out_ready(out_ready));
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkv(input string n, input logic [VW-1:0] e, input logic [VW-1:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chkv
	task automatic tmo();
		err_total++;
		$display("CHECK FAILED wait expected done seen timeout");
		give_verdict();
	endtask : tmo
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, reg_rdata);
	endtask : rd
	function automatic logic [VW-1:0] mk(int x, int z, int w, int d, int a);
		logic [VW-1:0] v;
		v = '0;
		v[0+:W_DEF] = W_DEF'(x);
		v[2*W_DEF+:W_DEF] = W_DEF'(z);
		v[3*W_DEF+:W_DEF] = W_DEF'(w);
		for (int k = 0; k < USR_DEF; k++) v[(NPOS+k)*W_DEF+:W_DEF] = W_DEF'(d);
		v[(NPOS+USR_DEF)*W_DEF+:W_DEF] = W_DEF'(a);
		v[(NPOS+USR_DEF+1)*W_DEF+:W_DEF] = W_DEF'(2 * a);
		v[(NPOS+USR_DEF+2)*W_DEF+:W_DEF] = W_DEF'(-a);
		v[(NPOS+USR_DEF+3)*W_DEF+:W_DEF] = W_DEF'(3 * a);
		return v;
	endfunction : mk
	task automatic prim(input logic [1:0] k, input logic [1:0] s, input logic [VW-1:0] a, b, c);
		int i;
		nv = 0;
		@(posedge clk);
		in_kind <= k;
		in_stream <= s;
		in_v0 <= a;
		in_v1 <= b;
		in_v2 <= c;
		in_valid <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (in_ready === 1'b1) break;
		end
		if (i == 20) tmo();
		in_valid <= 1'b0;
		for (i = 0; i < 900; i++) begin
			@(negedge clk);
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				if (nv == 0) fst = out_first;
				if (nv == 0) gk = out_kind;
				lst = out_last;
				if (nv < 4) got[nv] = out_vtx;
				nv++;
			end
			if (in_ready === 1'b1) break;
		end
		if (i == 900) tmo();
	endtask : prim
	task automatic t_point();
		logic [VW-1:0] p;
		p = mk(10, -100, 100, 1, 7);
		rd(CTRL_OFF, CTRL_RST);
		rd(8'h10, 32'h0000_0000);
		wr(CTRL_OFF, 32'h0000_00FF);
		prim(KIND_POINT, 2'h0, p, '0, '0);
		chk("pt_n", 32'd1, 32'(nv));
		chkv("pt_v", p, got[0]);
		chk("pt_f", 32'h0000_0003, {30'h0, fst, lst});
		prim(KIND_POINT, 2'h0, mk(0, 0, 100, 0, 7), '0, '0);
		chk("pt_d0", 32'd0, 32'(nv));
		prim(KIND_POINT, 2'h0, mk(0, 300, 100, 1, 7), '0, '0);
		chk("pt_z", 32'd0, 32'(nv));
		rd(DROP_OFF, 32'h0000_0002);
		wr(CTRL_OFF, 32'h0001_0000);
		prim(KIND_POINT, 2'h0, mk(0, 300, 100, 0, 7), '0, '0);
		chk("pt_byp", 32'd1, 32'(nv));
		$display("test point done");
	endtask : t_point
	task automatic t_line();
		slow <= 1'b1;
		wr(CTRL_OFF, 32'h0000_00FF);
		prim(KIND_LINE, 2'h0, mk(0, 0, 100, 1, 0), mk(200, 0, 100, 1, 400), '0);
		chk("ln_n", 32'd2, 32'(nv));
		chk("ln_k", 32'(KIND_LINE), 32'(gk));
		chkv("ln_v0", mk(0, 0, 100, 1, 0), got[0]);
		chkv("ln_v1", mk(100, 0, 100, 1, 200), got[1]);
		prim(KIND_TRI, 2'h0, mk(0, 0, 100, 1, 1), mk(50, 0, 100, 1, 2), mk(0, 50, 100, 1, 3));
		chk("tri_n", 32'd3, 32'(nv));
		chkv("tri_v2", mk(0, 50, 100, 1, 3), got[2]);
		chk("tri_f", 32'h0000_0003, {30'h0, fst, lst});
		slow <= 1'b0;
		$display("test line done");
	endtask : t_line
	// The far end has a larger w, so a screen-linear weight differs from the clip-space one.
	task automatic t_attr();
		logic [VW-1:0] a;
		logic [VW-1:0] b;
		a = mk(0, 0, 100, 1, 0);
		b = mk(400, 0, 300, 1, 400);
		wr(CTRL_OFF, 32'h0008_00FF);
		rd(CTRL_OFF, 32'h0008_00FF);
		prim(KIND_LINE, 2'h0, a, b, '0);
		chk("lin_n", 32'd2, 32'(nv));
		chkv("lin_v0", a, got[0]);
		chkv("lin_v1", mk(200, 0, 200, 1, 300), got[1]);
		chk("lin_f", 32'h0000_0003, {30'h0, fst, lst});
		wr(CTRL_OFF, 32'h0010_00FF);
		prim(KIND_LINE, 2'h0, a, b, '0);
		chk("int_n", 32'd2, 32'(nv));
		chkv("int_v1", mk(200, 0, 200, 1, 0), got[1]);
		wr(CTRL_OFF, 32'h0000_00FF);
		prim(KIND_TRI, 2'h0, a, mk(200, 0, 100, 1, 400), mk(0, 50, 100, 1, 200));
		chk("clip_n", 32'd4, 32'(nv));
		chk("clip_k", 32'(KIND_TRI), 32'(gk));
		chkv("clip_v0", a, got[0]);
		chkv("clip_v1", mk(100, 0, 100, 1, 200), got[1]);
		chkv("clip_v2", mk(100, 25, 100, 1, 300), got[2]);
		chkv("clip_v3", mk(0, 50, 100, 1, 200), got[3]);
		rd(STAT_OFF, 32'h0000_0000);
		$display("test attr done");
	endtask : t_attr
	task automatic wipe(input logic e);
		@(posedge clk);
		buffer_wipe_cmd <= 1'b1;
		@(posedge clk);
		buffer_wipe_cmd <= 1'b0;
		@(negedge clk);
		chk("wipe", 32'(e), 32'(wipe_out));
	endtask : wipe
	task automatic t_discard();
		wr(CTRL_OFF, 32'h0004_0000);
		prim(KIND_POINT, 2'h1, mk(0, 0, 100, 1, 5), '0, '0);
		chk("st1", 32'd0, 32'(nv));
		wr(CTRL_OFF, 32'h0000_0000);
		prim(KIND_POINT, 2'h1, mk(0, 0, 100, 1, 5), '0, '0);
		chk("st_nogeo", 32'd1, 32'(nv));
		wr(CTRL_OFF, 32'h0002_0000);
		prim(KIND_POINT, 2'h0, mk(0, 0, 100, 1, 5), '0, '0);
		chk("prd", 32'd0, 32'(nv));
		wipe(1'b0);
		wr(CTRL_OFF, 32'h0000_0000);
		wipe(1'b1);
		$display("test discard done");
	endtask : t_discard
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_point();
		t_line();
		t_attr();
		t_discard();
		give_verdict();
	end
endmodule : prim_clipper_tb_top
`default_nettype wire
